// ---- include/lpt_pkg.sv ----
// constants, command encoding and timing counts for the precharge/refresh tracker
package lpt_pkg;

   // ---------------------------------------------------------------
   // organisation and command/address bit positions
   // ---------------------------------------------------------------
   localparam int NUM_BANKS = 8;            // banks in the device
   localparam int BANK_W    = 3;            // bank address width
   localparam int CA_W      = 10;           // command/address bus width
   localparam int CA_OP0    = 0;            // opcode bit 0 (rising half)
   localparam int CA_OP1    = 1;            // opcode bit 1
   localparam int CA_OP2    = 2;            // opcode bit 2
   localparam int CA_OP3    = 3;            // opcode bit 3
   localparam int CA_ALLB   = 4;            // all-bank flag of precharge
   localparam int CA_BA_LO  = 7;            // bank address low bit
   localparam int CA_BA_HI  = 9;            // bank address high bit
   localparam int CA_APF    = 0;            // auto-precharge flag (falling half)

   // ---------------------------------------------------------------
   // burst setup and timing figures (picoseconds)
   // ---------------------------------------------------------------
   localparam int BURST_LEN      = 8;       // burst length
   localparam int WRITE_LAT      = 1;       // write latency in link clocks
   localparam int MEM_CLK_PS     = 80000;   // link clock period
   localparam int REF_CLK_PS     = 40000;   // ref_clk period
   localparam int T_WR_PS        = 15000;   // write recovery time
   localparam int T_RTP_PS       = 7500;    // read to precharge time
   localparam int T_RPPB_PS      = 18000;   // per bank precharge time
   localparam int T_RFCAB_PS     = 130000;  // all bank refresh cycle time
   localparam int T_REFI_PS      = 7800000; // average refresh interval

   // round up a least time to whole clocks, never below one
   function automatic int cyc_up(input int t_ps, input int clk_ps);
      int c;
      c = (t_ps + clk_ps - 1) / clk_ps;
      return (c < 1) ? 1 : c;
   endfunction

   // round down a longest time to whole clocks, never below one
   function automatic int cyc_dn(input int t_ps, input int clk_ps);
      int c;
      c = t_ps / clk_ps;
      return (c < 1) ? 1 : c;
   endfunction

   // ---------------------------------------------------------------
   // derived counts
   // ---------------------------------------------------------------
   localparam int WR_CYC   = cyc_up(T_WR_PS, MEM_CLK_PS);    // recovery clocks
   localparam int RTP_CYC  = cyc_up(T_RTP_PS, MEM_CLK_PS);   // read to precharge
   localparam int RPPB_CYC = cyc_up(T_RPPB_PS, MEM_CLK_PS);  // precharge clocks
   localparam int RFC_CYC  = cyc_up(T_RFCAB_PS, MEM_CLK_PS); // refresh busy clocks
   localparam int REFI_CYC = cyc_dn(T_REFI_PS, REF_CLK_PS);  // refresh interval
   // write w/ auto precharge: burst ends after latency + half burst + 1, then recovery
   localparam int WR_AP_CYC = WRITE_LAT + BURST_LEN / 2 + 1 + WR_CYC;
   // read w/ auto precharge: larger of half burst and the prefetch + read_to_precharge_time path
   localparam int RD_AP_CYC = (BURST_LEN / 2 > BURST_LEN / 2 - 2 + RTP_CYC) ?
                              BURST_LEN / 2 : BURST_LEN / 2 - 2 + RTP_CYC;

   localparam int CNT_W   = 8;              // per bank countdown width
   localparam int TOT_W   = 16;             // refresh total width
   localparam int IVL_W   = 10;             // interval timer width

   typedef logic [CNT_W-1:0] lpt_cnt_t;     // countdown value

   // decoded commands
   typedef enum logic [2:0] {
      CMD_NOP,
      CMD_ACT,
      CMD_WRITE,
      CMD_READ,
      CMD_PRE,
      CMD_TERM,
      CMD_REF_ALL,
      CMD_REF_BANK
   } lpt_cmd_e;

endpackage

// ---- include/lpt_cmd_if.sv ----
// decoded command carrier between decoder and bank tracker
`timescale 1ns/1ns
interface lpt_cmd_if;
   import lpt_pkg::*;
   lpt_cmd_e               cmd;        // decoded command, nop when idle
   logic [BANK_W-1:0]      bank;       // addressed bank
   logic                   ap;         // auto precharge flag
   logic                   all_banks;  // precharge targets every bank

   modport dec  (output cmd, output bank, output ap, output all_banks);
   modport core (input  cmd, input  bank, input  ap, input  all_banks);
endinterface

// ---- logic/lpt_cmd_decode.sv ----
// command/address decoder on the link clock
`timescale 1ns/1ns
module lpt_cmd_decode (
   input  wire logic                    mem_clk,    // link clock
   input  wire logic                    link_rst_b, // link domain reset, low
   input  wire logic                    cs_b,       // chip select, low
   input  wire logic [lpt_pkg::CA_W-1:0] ca_rise,   // rising half of bus
   input  wire logic [lpt_pkg::CA_W-1:0] ca_fall,   // falling half of bus
   lpt_cmd_if.dec                       cmd_if      // decoded command
);
   import lpt_pkg::*;

   lpt_cmd_e next_cmd;  // combinational decode

   // ---------------------------------------------------------------
   // opcode decode
   // ---------------------------------------------------------------
   always_comb begin
      next_cmd = CMD_NOP;
      if (!cs_b) begin
         if (!ca_rise[CA_OP0] && ca_rise[CA_OP1]) begin
            next_cmd = CMD_ACT;                                 // activate
         end else if (ca_rise[CA_OP0] && !ca_rise[CA_OP1]) begin
            next_cmd = ca_rise[CA_OP2] ? CMD_READ : CMD_WRITE;  // column access
         end else if (ca_rise[CA_OP0] && ca_rise[CA_OP1] && !ca_rise[CA_OP2]) begin
            next_cmd = ca_rise[CA_OP3] ? CMD_PRE : CMD_TERM;    // precharge / stop
         end else if (!ca_rise[CA_OP0] && !ca_rise[CA_OP1] && ca_rise[CA_OP2]) begin
            next_cmd = ca_rise[CA_OP3] ? CMD_REF_ALL : CMD_REF_BANK;
         end
      end
   end

   // ---------------------------------------------------------------
   // registered command outputs
   // ---------------------------------------------------------------
   always_ff @(posedge mem_clk) begin
      if (!link_rst_b) begin
         cmd_if.cmd       <= CMD_NOP;
         cmd_if.bank      <= '0;
         cmd_if.ap        <= 1'b0;
         cmd_if.all_banks <= 1'b0;
      end else begin
         cmd_if.cmd       <= next_cmd;
         cmd_if.bank      <= ca_rise[CA_BA_HI:CA_BA_LO];
         cmd_if.ap        <= ca_fall[CA_APF];
         cmd_if.all_banks <= ca_rise[CA_ALLB];
      end
   end
endmodule // lpt_cmd_decode

// ---- logic/lpt_top.sv ----
// bank precharge, auto-precharge and refresh tracker for an eight bank sdram
`timescale 1ns/1ns
module lpt_top (
   input  wire logic                     ref_clk,          // system clock
   input  wire logic                     rst_b,            // sync reset, low
   input  wire logic                     mem_clk,          // link clock
   input  wire logic                     cs_b,             // chip select, low
   input  wire logic [lpt_pkg::CA_W-1:0] ca_rise,          // rising half of bus
   input  wire logic [lpt_pkg::CA_W-1:0] ca_fall,          // falling half of bus
   output logic [lpt_pkg::NUM_BANKS-1:0] bank_open,        // row open per bank
   output logic [lpt_pkg::NUM_BANKS-1:0] bank_busy,        // precharging or auto precharge pending per bank
   output logic                          refresh_busy,     // all bank refresh cycle running
   output logic                          refresh_pulse,    // one pulse per refresh
   output logic [lpt_pkg::BANK_W-1:0]    refresh_bank_ptr, // refresh bank counter
   output logic [lpt_pkg::TOT_W-1:0]     refresh_total,    // refreshes seen
   output logic                          refresh_late,     // interval overrun
   output logic                          access_error      // read or write to a bank with auto precharge pending
);
   import lpt_pkg::*;

   // ---------------------------------------------------------------
   // link domain reset
   // ---------------------------------------------------------------
   logic [1:0] link_rst_sync;  // reset carried onto the link clock
   logic       link_rst_b;     // link domain reset, low

   // two stage capture of the reset level
   always_ff @(posedge mem_clk) begin
      link_rst_sync <= {link_rst_sync[0], rst_b};
   end
   assign link_rst_b = link_rst_sync[1];

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   lpt_cmd_if cmd_if ();  // decoded command carrier

   lpt_cmd_decode u_dec (
      .mem_clk    (mem_clk),
      .link_rst_b (link_rst_b),
      .cs_b       (cs_b),
      .ca_rise    (ca_rise),
      .ca_fall    (ca_fall),
      .cmd_if     (cmd_if)
   );

   // ---------------------------------------------------------------
   // link domain bank state
   // ---------------------------------------------------------------
   logic [NUM_BANKS-1:0] open_l;                // row open
   lpt_cnt_t             ap_cnt  [NUM_BANKS];   // auto precharge countdown
   lpt_cnt_t             pre_cnt [NUM_BANKS];   // precharge countdown
   logic [NUM_BANKS-1:0] busy_l;                // precharge or pending
   logic [NUM_BANKS-1:0] cross_busy;            // busy, from a flop for the crossing
   logic                 cross_rfb;             // refresh busy, from a flop
   lpt_cnt_t             rfc_cnt;               // refresh cycle countdown
   logic [BANK_W-1:0]    ref_ptr_l;             // refresh bank counter
   logic                 ref_tgl_l;             // toggles on each refresh
   logic                 err_tgl_l;             // toggles on illegal access
   logic                 is_ref;                // refresh decoded this clock

   assign is_ref = (cmd_if.cmd == CMD_REF_ALL) || (cmd_if.cmd == CMD_REF_BANK);

   // per bank open/precharge tracking
   always_ff @(posedge mem_clk) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
         if (!link_rst_b) begin
            open_l[b]  <= 1'b0;
            ap_cnt[b]  <= '0;
            pre_cnt[b] <= '0;
         end else if (cmd_if.cmd == CMD_REF_ALL) begin
            open_l[b]  <= 1'b0;
            ap_cnt[b]  <= '0;
            pre_cnt[b] <= '0;
         end else begin
            // countdowns
            if (ap_cnt[b] != '0) begin
               ap_cnt[b] <= ap_cnt[b] - 1'b1;
               if (ap_cnt[b] == lpt_cnt_t'(1)) begin
                  open_l[b]  <= 1'b0;
                  pre_cnt[b] <= lpt_cnt_t'(RPPB_CYC);
               end
            end else if (pre_cnt[b] != '0) begin
               pre_cnt[b] <= pre_cnt[b] - 1'b1;
            end
            // commands addressed to this bank
            if (cmd_if.cmd == CMD_ACT && cmd_if.bank == BANK_W'(b)) begin
               open_l[b] <= 1'b1;
            end else if (cmd_if.cmd == CMD_PRE &&
                         (cmd_if.all_banks || cmd_if.bank == BANK_W'(b))) begin
               open_l[b]  <= 1'b0;
               pre_cnt[b] <= lpt_cnt_t'(RPPB_CYC);
            end else if (cmd_if.cmd == CMD_WRITE && cmd_if.ap &&
                         cmd_if.bank == BANK_W'(b)) begin
               ap_cnt[b] <= lpt_cnt_t'(WR_AP_CYC);
            end else if (cmd_if.cmd == CMD_READ && cmd_if.ap &&
                         cmd_if.bank == BANK_W'(b)) begin
               ap_cnt[b] <= lpt_cnt_t'(RD_AP_CYC);
            end
         end
      end
   end

   // busy while auto precharge pending or precharge running
   always_comb begin
      for (int b = 0; b < NUM_BANKS; b++) begin
         busy_l[b] = (ap_cnt[b] != '0) || (pre_cnt[b] != '0);
      end
   end

   // levels leave the link domain from flops, so no decode glitch is synchronised
   always_ff @(posedge mem_clk) begin
      if (!link_rst_b) begin
         cross_busy <= '0;
         cross_rfb  <= 1'b0;
      end else begin
         cross_busy <= busy_l;
         cross_rfb  <= (rfc_cnt != '0);
      end
   end

   // refresh cycle timer and bank counter
   always_ff @(posedge mem_clk) begin
      if (!link_rst_b) begin
         rfc_cnt   <= '0;
         ref_ptr_l <= '0;
      end else if (cmd_if.cmd == CMD_REF_ALL) begin
         rfc_cnt   <= lpt_cnt_t'(RFC_CYC);
         ref_ptr_l <= '0;
      end else begin
         if (rfc_cnt != '0) begin
            rfc_cnt <= rfc_cnt - 1'b1;
         end
         if (cmd_if.cmd == CMD_REF_BANK) begin
            ref_ptr_l <= ref_ptr_l + 1'b1;
         end
      end
   end

   // event toggles for crossing to ref_clk
   always_ff @(posedge mem_clk) begin
      if (!link_rst_b) begin
         ref_tgl_l <= 1'b0;
         err_tgl_l <= 1'b0;
      end else begin
         if (is_ref) begin
            ref_tgl_l <= ~ref_tgl_l;
         end
         // read or write to a bank still closing by auto precharge
         if ((cmd_if.cmd == CMD_READ || cmd_if.cmd == CMD_WRITE) &&
             ap_cnt[cmd_if.bank] != '0) begin
            err_tgl_l <= ~err_tgl_l;
         end
      end
   end

   // ---------------------------------------------------------------
   // crossing into ref_clk
   // ---------------------------------------------------------------
   logic [NUM_BANKS-1:0] open_s1, busy_s1;  // first stages
   logic [NUM_BANKS-1:0] open_s2, busy_s2;  // second stages
   logic                 rfb_s1, rfb_s2;    // refresh busy stages
   logic [2:0]           ref_tgl_s;         // refresh toggle stages
   logic [2:0]           err_tgl_s;         // error toggle stages
   logic                 ref_evt;           // refresh event in ref_clk
   logic                 err_evt;           // error event in ref_clk

   // two flop level synchronisers and three flop toggle chains
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         open_s1   <= '0;
         open_s2   <= '0;
         busy_s1   <= '0;
         busy_s2   <= '0;
         rfb_s1    <= 1'b0;
         rfb_s2    <= 1'b0;
         ref_tgl_s <= '0;
         err_tgl_s <= '0;
      end else begin
         open_s1   <= open_l;
         open_s2   <= open_s1;
         busy_s1   <= cross_busy;
         busy_s2   <= busy_s1;
         rfb_s1    <= cross_rfb;
         rfb_s2    <= rfb_s1;
         ref_tgl_s <= {ref_tgl_s[1:0], ref_tgl_l};
         err_tgl_s <= {err_tgl_s[1:0], err_tgl_l};
      end
   end

   assign ref_evt = ref_tgl_s[2] ^ ref_tgl_s[1];
   assign err_evt = err_tgl_s[2] ^ err_tgl_s[1];

   // ---------------------------------------------------------------
   // ref_clk status
   // ---------------------------------------------------------------
   logic [IVL_W-1:0] ivl_cnt;  // clocks since last refresh

   // registered level outputs and refresh pulse
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         bank_open     <= '0;
         bank_busy     <= '0;
         refresh_busy  <= 1'b0;
         refresh_pulse <= 1'b0;
      end else begin
         bank_open     <= open_s2;
         bank_busy     <= busy_s2;
         refresh_busy  <= rfb_s2;
         refresh_pulse <= ref_evt;
      end
   end

   // bank counter word: stable in link domain once the toggle has landed
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         refresh_bank_ptr <= '0;
      end else if (ref_evt) begin
         refresh_bank_ptr <= ref_ptr_l;
      end
   end

   // refresh count and interval watch
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         refresh_total <= '0;
         ivl_cnt       <= '0;
         refresh_late  <= 1'b0;
      end else if (ref_evt) begin
         refresh_total <= refresh_total + 1'b1;
         ivl_cnt       <= '0;
         refresh_late  <= 1'b0;
      end else begin
         if (ivl_cnt != IVL_W'(REFI_CYC)) begin
            ivl_cnt <= ivl_cnt + 1'b1;
         end else begin
            refresh_late <= 1'b1;
         end
      end
   end

   // sticky access error flag, cleared only by reset
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         access_error <= 1'b0;
      end else if (err_evt) begin
         access_error <= 1'b1;
      end
   end
endmodule // lpt_top

// ---- sim/lpt_top_properties.sv ----
// concurrent checks on the precharge and refresh tracker ports
`timescale 1ns/1ns
module lpt_chk (
   input wire logic                           ref_clk,          // system clock
   input wire logic                           rst_b,            // sync reset, low
   input wire logic                           mem_clk,          // link clock
   input wire logic                           cs_b,             // chip select, low
   input wire logic [lpt_pkg::CA_W-1:0]       ca_rise,          // rising half
   input wire logic [lpt_pkg::CA_W-1:0]       ca_fall,          // falling half
   input wire logic [lpt_pkg::NUM_BANKS-1:0]  bank_open,        // open rows
   input wire logic [lpt_pkg::NUM_BANKS-1:0]  bank_busy,        // closing banks
   input wire logic                           refresh_busy,     // all bank refresh running
   input wire logic                           refresh_pulse,    // refresh seen
   input wire logic [lpt_pkg::BANK_W-1:0]     refresh_bank_ptr, // bank counter
   input wire logic [lpt_pkg::TOT_W-1:0]      refresh_total,    // refresh count
   input wire logic                           refresh_late,     // interval overrun
   input wire logic                           access_error      // auto precharge pending bank hit
);
   import lpt_pkg::*;
   // ---------------------------------------------
   // helper logic
   // ---------------------------------------------
   logic [15:0]       idle_cnt; // cycles since last refresh pulse
   logic [BANK_W-1:0] ap_bank;  // bank of latest write w/ auto precharge
   logic              wr_ap;    // write w/ auto precharge on the bus
   assign wr_ap = !cs_b && ca_rise[CA_OP0] && !ca_rise[CA_OP1] && !ca_rise[CA_OP2]
                  && ca_fall[CA_APF];
   // idle counter, saturating
   always_ff @(posedge ref_clk) begin
      if (!rst_b || refresh_pulse) begin
         idle_cnt <= 16'h0000;
      end else if (idle_cnt != 16'hffff) begin
         idle_cnt <= idle_cnt + 16'h0001;
      end
   end
   // remember bank of the auto precharge write
   always_ff @(posedge mem_clk) begin
      if (wr_ap) begin
         ap_bank <= ca_rise[CA_BA_HI:CA_BA_LO];
      end
   end
   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   pulse_single_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      refresh_pulse |=> !refresh_pulse) else $error("refresh pulse too long");
   total_step_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $changed(refresh_total) |-> refresh_total == $past(refresh_total) + 16'h0001)
      else $error("refresh total jumped");
   error_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      access_error |=> access_error) else $error("access error dropped");
   refresh_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(refresh_busy) |-> ##[0:3] (bank_open == 8'h00 && bank_busy == 8'h00))
      else $error("banks not idle at refresh");
   refresh_len_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(refresh_busy) |=> refresh_busy ##[1:7] !refresh_busy)
      else $error("refresh busy length wrong");
   ptr_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(refresh_busy) |-> ##[0:6] (refresh_bank_ptr == 3'h0))
      else $error("refresh pointer not cleared");
   late_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      idle_cnt == 16'h00c8 |-> refresh_late) else $error("late flag missing");
   late_early_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      refresh_late |-> (idle_cnt >= 16'h00be || idle_cnt < 16'h0004))
      else $error("late flag too early");
   wrap_busy_a: assert property (@(posedge mem_clk) disable iff (!rst_b)
      wr_ap |-> ##5 bank_busy[ap_bank] [*5] ##[1:8] !bank_busy[ap_bank])
      else $error("auto precharge window wrong");
endmodule // lpt_chk

bind lpt_top lpt_chk chk_u (
   .ref_clk(ref_clk), .rst_b(rst_b), .mem_clk(mem_clk), .cs_b(cs_b),
   .ca_rise(ca_rise), .ca_fall(ca_fall), .bank_open(bank_open), .bank_busy(bank_busy),
   .refresh_busy(refresh_busy), .refresh_pulse(refresh_pulse),
   .refresh_bank_ptr(refresh_bank_ptr), .refresh_total(refresh_total),
   .refresh_late(refresh_late), .access_error(access_error));

// ---- sim/lpt_ctrl_model.sv ----
// memory controller model driving the command/address bus
`timescale 1ns/1ns
module lpt_ctrl_model #(
   parameter int T_RRD_CYC = 2  // activate to activate clocks
) (
   input  wire logic                     mem_clk, // link clock
   output logic                          cs_b,    // chip select, low
   output logic [lpt_pkg::CA_W-1:0]      ca_rise, // rising half
   output logic [lpt_pkg::CA_W-1:0]      ca_fall  // falling half
);
   import lpt_pkg::*;
   // ---------------------------------------------
   // opcodes and spacing in link clocks
   // ---------------------------------------------
   localparam logic [3:0] OP_ACT = 4'h2, OP_WR = 4'h1, OP_RD = 4'h5, OP_PRE = 4'hb;
   localparam logic [3:0] OP_TERM = 4'h3, OP_REFA = 4'hc, OP_REFB = 4'h4;
   localparam int GAP_ACT   = T_RRD_CYC;
   localparam int GAP_WR_AP = WRITE_LAT + BURST_LEN / 2 + WR_CYC + 1 + RPPB_CYC;
   localparam int GAP_RD_AP = BURST_LEN / 2 + ((RTP_CYC > 2) ? RTP_CYC : 2) - 2
                              + RPPB_CYC;
   localparam int GAP_PRE   = RPPB_CYC;
   localparam int GAP_TERM  = 1;
   localparam int GAP_REF   = 4 * RFC_CYC;
   // no self refresh here: no count credit, no entry after a burst
   initial begin
      cs_b    = 1'b1;
      ca_rise = 10'h000;
      ca_fall = 10'h000;
   end
   // one command, then idle clocks; deselected bus shows the inverse
   // callers pass the idle clocks to wait; several pass zero so the next command follows after the one deselected clock
   task automatic send(input logic [3:0] op, input logic allb, input logic [2:0] bank,
                       input logic apf, input int gap);
      @(posedge mem_clk);
      cs_b    <= 1'b0;
      ca_rise <= {bank, 2'b00, allb, op};
      ca_fall <= {9'h000, apf};
      @(posedge mem_clk);
      cs_b    <= 1'b1;
      ca_rise <= ~{bank, 2'b00, allb, op};
      ca_fall <= ~{9'h000, apf};
      repeat (gap) @(posedge mem_clk);
   endtask
endmodule // lpt_ctrl_model

// ---- sim/tb_lpddr2_precharge_refresh_timing.sv ----
// testbench for the precharge and refresh tracker
`timescale 1ns/1ns
module tb_lpddr2_precharge_refresh_timing;
   import lpt_pkg::*;
   // ---------------------------------------------
   // signals and reference model state
   // ---------------------------------------------
   logic              ref_clk, mem_clk, rst_b, cs_b;     // clocks and controls
   logic [CA_W-1:0]   ca_rise, ca_fall;                  // command bus
   logic [7:0]        bank_open, bank_busy;              // bank state
   logic              refresh_busy, refresh_pulse, refresh_late, access_error;
   logic [2:0]        refresh_bank_ptr;                  // refresh counter
   logic [15:0]       refresh_total;                     // refreshes seen
   int                error_cnt, n_compared, i, b, exp_total, exp_ptr;
   logic [7:0]        exp_open;                          // expected open rows
   logic              exp_err;                           // expected error flag
   logic [31:0]       seed;                              // xorshift state
   lpt_top dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .mem_clk(mem_clk), .cs_b(cs_b),
      .ca_rise(ca_rise), .ca_fall(ca_fall), .bank_open(bank_open), .bank_busy(bank_busy),
      .refresh_busy(refresh_busy), .refresh_pulse(refresh_pulse),
      .refresh_bank_ptr(refresh_bank_ptr), .refresh_total(refresh_total),
      .refresh_late(refresh_late), .access_error(access_error));
   lpt_ctrl_model ctrl_u (.mem_clk(mem_clk), .cs_b(cs_b), .ca_rise(ca_rise),
      .ca_fall(ca_fall));
   // clocks, unrelated phase
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   initial begin
      mem_clk = 1'b0;
      #13;
      forever #40 mem_clk = ~mem_clk;
   end
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask
   // let status cross to ref_clk, then compare open rows, refresh total, bank counter and error flag
   task automatic check_state();
      repeat (10) @(negedge ref_clk);
      chk_vec({8'h00, bank_open}, {8'h00, exp_open});
      chk_vec(refresh_total, exp_total[15:0]);
      chk_vec({13'h0000, refresh_bank_ptr}, exp_ptr[15:0]);
      chk_bit(access_error, exp_err);
   endtask
   task automatic tally_and_finish();
      $display("errors=%0d compared=%0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      #400000;
      error_cnt++;
      tally_and_finish();
   end
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      rst_b = 1'b0;
      seed = 32'hcfd0;
      error_cnt = 0;
      n_compared = 0;
      exp_total = 0;
      exp_ptr = 0;
      exp_open = 8'h00;
      exp_err = 1'b0;
      repeat (4) @(posedge mem_clk);
      @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge mem_clk);
      check_state();
      // activate then write w/ auto precharge on random banks
      for (i = 0; i < 4; i++) begin
         b = rnd() % 8;
         ctrl_u.send(ctrl_u.OP_ACT, 1'b0, b[2:0], 1'b0, ctrl_u.GAP_ACT);
         exp_open[b] = 1'b1;
         check_state();
         ctrl_u.send(ctrl_u.OP_WR, 1'b0, b[2:0], 1'b1, 0);
         repeat (5) @(posedge mem_clk);
         chk_bit(bank_busy[b], 1'b1);
         repeat (ctrl_u.GAP_WR_AP) @(posedge mem_clk);
         exp_open[b] = 1'b0;
         check_state();
         chk_bit(bank_busy[b], 1'b0);
      end
      // read, stop, precharge; then two rows closed by single and all precharge
      ctrl_u.send(ctrl_u.OP_ACT, 1'b0, 3'h2, 1'b0, ctrl_u.GAP_ACT);
      ctrl_u.send(ctrl_u.OP_RD, 1'b0, 3'h2, 1'b0, 0);
      ctrl_u.send(ctrl_u.OP_TERM, 1'b0, 3'h2, 1'b0, ctrl_u.GAP_TERM);
      ctrl_u.send(ctrl_u.OP_PRE, 1'b0, 3'h2, 1'b0, ctrl_u.GAP_PRE);
      ctrl_u.send(ctrl_u.OP_ACT, 1'b0, 3'h5, 1'b0, ctrl_u.GAP_ACT);
      ctrl_u.send(ctrl_u.OP_ACT, 1'b0, 3'h6, 1'b0, ctrl_u.GAP_ACT);
      exp_open = 8'h60;
      check_state();
      ctrl_u.send(ctrl_u.OP_PRE, 1'b0, 3'h5, 1'b0, 0);
      ctrl_u.send(ctrl_u.OP_PRE, 1'b1, 3'h0, 1'b0, ctrl_u.GAP_PRE);
      exp_open = 8'h00;
      check_state();
      // refreshes of both kinds in random order
      for (i = 0; i < 12; i++) begin
         if (rnd() % 2 == 0) begin
            ctrl_u.send(ctrl_u.OP_REFA, 1'b0, 3'h0, 1'b0, ctrl_u.GAP_REF);
            exp_ptr = 0;
         end else begin
            ctrl_u.send(ctrl_u.OP_REFB, 1'b0, 3'h0, 1'b0, ctrl_u.GAP_REF);
            exp_ptr = (exp_ptr + 1) % 8;
         end
         exp_total++;
         check_state();
      end
      // interval overrun, then cleared by a refresh
      repeat (210) @(negedge ref_clk);
      chk_bit(refresh_late, 1'b1);
      ctrl_u.send(ctrl_u.OP_REFA, 1'b0, 3'h0, 1'b0, ctrl_u.GAP_REF);
      exp_total++;
      exp_ptr = 0;
      check_state();
      chk_bit(refresh_late, 1'b0);
      // read w/ auto precharge, then a write into the closing bank on purpose
      ctrl_u.send(ctrl_u.OP_ACT, 1'b0, 3'h3, 1'b0, ctrl_u.GAP_ACT);
      ctrl_u.send(ctrl_u.OP_RD, 1'b0, 3'h3, 1'b1, 0);
      ctrl_u.send(ctrl_u.OP_WR, 1'b0, 3'h3, 1'b0, ctrl_u.GAP_RD_AP);
      exp_err = 1'b1;
      check_state();
      tally_and_finish();
   end
endmodule // tb_lpddr2_precharge_refresh_timing
